/* gbt_pkg.sv */
/*
  constants and types shared by the group base timer.
  assumes a 32-bit register port with byte offsets on a word grid.
*/
package gbt_pkg;
  // register byte offsets
  localparam int unsigned GBT_AW = 5;
  localparam logic [4:0] GBT_OFS_CTRL   = 5'h00;
  localparam logic [4:0] GBT_OFS_START  = 5'h04;
  localparam logic [4:0] GBT_OFS_PINSEL = 5'h08;
  localparam logic [4:0] GBT_OFS_CMP0   = 5'h0C;
  localparam logic [4:0] GBT_OFS_COUNT  = 5'h10;
  localparam logic [4:0] GBT_OFS_CMP2   = 5'h14;
  localparam logic [4:0] GBT_OFS_G2CR   = 5'h18;
  // field positions
  localparam int unsigned GBT_BIT_MATCH_RST = 0;
  localparam int unsigned GBT_BIT_PIN_RST   = 2;
  localparam int unsigned GBT_BIT_MODE_LO   = 5;
  localparam int unsigned GBT_BIT_MODE_HI   = 6;
  localparam int unsigned GBT_BIT_COMMON_ST = 0;
  localparam int unsigned GBT_BIT_GROUP_ST  = 1;
  localparam int unsigned GBT_BIT_G0_SEL_LO = 22;
  localparam int unsigned GBT_BIT_G1_SEL_LO = 26;
  localparam int unsigned GBT_BIT_TXPOL     = 0;
  localparam int unsigned GBT_BIT_RXPOL     = 1;
  localparam int unsigned GBT_N_W           = 6;
  localparam int unsigned GBT_M_W           = 10;
  localparam int unsigned GBT_W             = 16;
  // pin selector codes
  localparam logic [1:0] GBT_SEL_PIN_A = 2'h0;
  localparam logic [1:0] GBT_SEL_PIN_B = 2'h1;
  // up steps left after a compare match before turning down
  localparam logic [1:0] GBT_MATCH_DELAY = 2'h2;
  // count modes
  typedef enum logic [1:0] {
    GBT_MODE_UP   = 2'b00,
    GBT_MODE_UPDN = 2'b01,
    GBT_MODE_QUAD = 2'b10,
    GBT_MODE_BAD  = 2'b11
  } gbt_mode_type;
  // control register fields
  typedef struct packed {
    gbt_mode_type mode;
    logic         pin_rst;
    logic         match_rst;
  } gbt_ctrl_type;
  // start bits
  typedef struct packed {
    logic group_st;
    logic common_st;
  } gbt_start_type;
  // serial pin polarity
  typedef struct packed {
    logic rx_pol;
    logic tx_pol;
  } gbt_pol_type;
  localparam gbt_ctrl_type  GBT_CTRL_RST  = '{GBT_MODE_UP, 1'b0, 1'b0};
  localparam gbt_start_type GBT_START_RST = '{1'b0, 1'b0};
  localparam gbt_pol_type   GBT_POL_RST   = '{1'b0, 1'b0};
endpackage

/* gbt_base_timer.sv */
/*
  group base timer: counter in up, up/down or two-phase mode, with pin
  and compare-match reset, compare value split and serial pin polarity.
  assumes all inputs are synchronous to clk_i and count_en_i is a
  one-cycle pulse from the group count clock divider.
*/
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
// Notes on behaviour
// - pin reset bit: off or low-pin reset
// - selected interrupt pin low resets timer
// - per-group two-bit pin selector field
// - mode field: up, up/down, two-phase
// - common or group start bit runs timer
// - up/down turns at all-ones and zero
// - match turns down two counts later
// - group 2 compare splits n and m
// - tx and rx pin polarity bits
`timescale 1ns/1ps
module gbt_base_timer
  import gbt_pkg::*;
#(
  parameter int unsigned GROUP = 0,              // 0 or 1: picks the pin selector
  parameter int unsigned CNT_W = gbt_pkg::GBT_W  // counter width
) (
  input  wire logic                         clk_i,
  input  wire logic                         reset_i,
  input  wire logic [gbt_pkg::GBT_AW-1:0]   addr_i,
  input  wire logic [31:0]                  wdata_i,
  input  wire logic                         we_i,
  input  wire logic                         re_i,
  output logic      [31:0]                  rdata_o,
  input  wire logic                         count_en_i,
  input  wire logic                         ext_irq_pin_a_i,
  input  wire logic                         ext_irq_pin_b_i,
  input  wire logic                         phase_a_i,
  input  wire logic                         phase_b_i,
  input  wire logic                         tx_data_i,
  input  wire logic                         group2_serial_rx_pin_i,
  output logic                              group2_serial_tx_pin_o,
  output logic                              rx_data_o,
  output logic      [CNT_W-1:0]             count_o,
  output logic                              count_up_o,
  output logic      [gbt_pkg::GBT_N_W-1:0]  cmp_n_o,
  output logic      [gbt_pkg::GBT_M_W-1:0]  cmp_m_o
);
  import gbt_pkg::*;

  localparam int unsigned SEL_LO = (GROUP == 1) ? GBT_BIT_G1_SEL_LO : GBT_BIT_G0_SEL_LO;
  localparam int unsigned CMP2_W = GBT_N_W + GBT_M_W;

  // register state
  gbt_ctrl_type         ctrl_q, ctrl_d;     // group_timer_control_1
  gbt_start_type        start_q, start_d;   // common and group start
  logic [1:0]           sel_q, sel_d;       // this group's pin selector
  logic [CNT_W-1:0]     cmp0_q, cmp0_d;     // group_compare_zero
  logic [CMP2_W-1:0]    cmp2_q, cmp2_d;     // group2_compare_value
  gbt_pol_type          pol_q, pol_d;       // polarity bits
  logic [31:0]          rdata_d;
  // counter state
  logic [CNT_W-1:0]     cnt_q, cnt_d;
  logic                 up_q, up_d;         // 1 while counting up
  logic [1:0]           pend_q, pend_d;     // up steps left before turn
  logic                 qa_q, qb_q;         // previous phase samples
  logic                 tx_q, tx_d;
  logic                 rx_q, rx_d;
  // decoded terms
  logic                 run;
  logic                 pin_hit;
  logic                 match_hit;
  logic                 quad_chg;
  logic                 quad_up;
  logic                 step;

  // register writes and read mux
  always_comb begin
    ctrl_d  = ctrl_q;
    start_d = start_q;
    sel_d   = sel_q;
    cmp0_d  = cmp0_q;
    cmp2_d  = cmp2_q;
    pol_d   = pol_q;
    rdata_d = '0;
    if (we_i) begin
      unique case (addr_i)
        GBT_OFS_CTRL: begin
          // the prohibited mode code is stored but never counts
          ctrl_d.mode      = gbt_mode_type'(wdata_i[GBT_BIT_MODE_HI:GBT_BIT_MODE_LO]);
          ctrl_d.pin_rst   = wdata_i[GBT_BIT_PIN_RST];
          ctrl_d.match_rst = wdata_i[GBT_BIT_MATCH_RST];
        end
        GBT_OFS_START: begin
          start_d.common_st = wdata_i[GBT_BIT_COMMON_ST];
          start_d.group_st  = wdata_i[GBT_BIT_GROUP_ST];
        end
        GBT_OFS_PINSEL: sel_d = wdata_i[SEL_LO+1:SEL_LO];
        GBT_OFS_CMP0:   cmp0_d = wdata_i[CNT_W-1:0];
        GBT_OFS_CMP2:   cmp2_d = wdata_i[CMP2_W-1:0];
        GBT_OFS_G2CR: begin
          pol_d.tx_pol = wdata_i[GBT_BIT_TXPOL];
          pol_d.rx_pol = wdata_i[GBT_BIT_RXPOL];
        end
        default: ;  // unmapped writes are dropped
      endcase
    end
    // read data stand only in the cycle after the strobe
    if (re_i) begin
      unique case (addr_i)
        GBT_OFS_CTRL: begin
          rdata_d[GBT_BIT_MODE_HI:GBT_BIT_MODE_LO] = ctrl_q.mode;
          rdata_d[GBT_BIT_PIN_RST]   = ctrl_q.pin_rst;
          rdata_d[GBT_BIT_MATCH_RST] = ctrl_q.match_rst;
        end
        GBT_OFS_START: begin
          rdata_d[GBT_BIT_COMMON_ST] = start_q.common_st;
          rdata_d[GBT_BIT_GROUP_ST]  = start_q.group_st;
        end
        GBT_OFS_PINSEL: rdata_d[SEL_LO+1:SEL_LO] = sel_q;
        GBT_OFS_CMP0:   rdata_d[CNT_W-1:0] = cmp0_q;
        GBT_OFS_COUNT:  rdata_d[CNT_W-1:0] = cnt_q;
        GBT_OFS_CMP2:   rdata_d[CMP2_W-1:0] = cmp2_q;
        GBT_OFS_G2CR: begin
          rdata_d[GBT_BIT_TXPOL] = pol_q.tx_pol;
          rdata_d[GBT_BIT_RXPOL] = pol_q.rx_pol;
        end
        default: rdata_d = '0;  // unmapped reads give zero
      endcase
    end
  end

  // register file flops
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q  <= GBT_CTRL_RST;
      start_q <= GBT_START_RST;
      sel_q   <= GBT_SEL_PIN_A;
      cmp0_q  <= '0;
      cmp2_q  <= '0;
      pol_q   <= GBT_POL_RST;
      rdata_o <= '0;
    end else begin
      ctrl_q  <= ctrl_d;
      start_q <= start_d;
      sel_q   <= sel_d;
      cmp0_q  <= cmp0_d;
      cmp2_q  <= cmp2_d;
      pol_q   <= pol_d;
      rdata_o <= rdata_d;
    end
  end

  // decode of run, reset sources and two-phase input
  always_comb begin
    run = start_q.common_st | start_q.group_st;
    // a low level on the selected pin holds the timer at zero
    unique case (sel_q)
      GBT_SEL_PIN_A: pin_hit = ctrl_q.pin_rst & ~ext_irq_pin_a_i;
      GBT_SEL_PIN_B: pin_hit = ctrl_q.pin_rst & ~ext_irq_pin_b_i;
      default:       pin_hit = 1'b0;  // unused selector codes pick no pin
    endcase
    // a match counts in up mode, or while heading up with no turn pending;
    // a pending count left from up/down mode must not mask up-mode matches
    match_hit = ctrl_q.match_rst && (cnt_q == cmp0_q) &&
                ((ctrl_q.mode == GBT_MODE_UP) ||
                 ((ctrl_q.mode == GBT_MODE_UPDN) && up_q && (pend_q == '0)));
    // quadrature: direction is new a against old b
    quad_chg = (phase_a_i ^ qa_q) | (phase_b_i ^ qb_q);
    quad_up  = phase_a_i ^ qb_q;
    step = run && ((ctrl_q.mode == GBT_MODE_QUAD) ? quad_chg : count_en_i);
  end

  // counter next state
  always_comb begin
    cnt_d  = cnt_q;
    up_d   = up_q;
    pend_d = pend_q;
    tx_d   = tx_data_i ^ pol_q.tx_pol;
    rx_d   = group2_serial_rx_pin_i ^ pol_q.rx_pol;
    if (pin_hit) begin
      // clear and keep the mode; counting resumes when the pin rises
      cnt_d  = '0;
      up_d   = 1'b1;
      pend_d = '0;
    end else if (step) begin
      unique case (ctrl_q.mode)
        GBT_MODE_UP: begin
          if (match_hit) begin
            cnt_d = '0;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        GBT_MODE_UPDN: begin
          if (up_q) begin
            if (cnt_q == '1) begin
              cnt_d = cnt_q - 1'b1;
              up_d  = 1'b0;
            end else begin
              cnt_d = cnt_q + 1'b1;
            end
            // at all-ones the turn is already made, so nothing is armed there
            if (match_hit && (cnt_q != '1)) begin
              pend_d = GBT_MATCH_DELAY - 2'h1;
            end else if (pend_q != '0) begin
              pend_d = pend_q - 2'h1;
              if (pend_q == 2'h1) begin
                up_d = 1'b0;
              end
            end
          end else begin
            if (cnt_q == '0) begin
              cnt_d = cnt_q + 1'b1;
              up_d  = 1'b1;
            end else begin
              cnt_d = cnt_q - 1'b1;
            end
          end
        end
        GBT_MODE_QUAD: begin
          cnt_d = quad_up ? cnt_q + 1'b1 : cnt_q - 1'b1;
        end
        GBT_MODE_BAD: cnt_d = cnt_q;
      endcase
    end
  end

  // counter flops
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q  <= '0;
      up_q   <= 1'b1;
      pend_q <= '0;
      qa_q   <= 1'b0;
      qb_q   <= 1'b0;
      tx_q   <= 1'b0;
      rx_q   <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      up_q   <= up_d;
      pend_q <= pend_d;
      qa_q   <= phase_a_i;
      qb_q   <= phase_b_i;
      tx_q   <= tx_d;
      rx_q   <= rx_d;
    end
  end

  // outputs straight from flops
  assign count_o                = cnt_q;
  assign count_up_o             = up_q;
  assign cmp_n_o                = cmp2_q[CMP2_W-1:GBT_M_W];
  assign cmp_m_o                = cmp2_q[GBT_M_W-1:0];
  assign group2_serial_tx_pin_o = tx_q;
  assign rx_data_o              = rx_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_pin_reset;
    ctrl_q.pin_rst && (sel_q == GBT_SEL_PIN_B) && !ext_irq_pin_b_i |=> cnt_q == '0;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin b low did not clear");

  property p_pin_off;
    !ctrl_q.pin_rst && !ext_irq_pin_a_i && run && count_en_i &&
    (ctrl_q.mode == GBT_MODE_UP) && !ctrl_q.match_rst && (cnt_q != '1)
    |=> cnt_q == $past(cnt_q) + 1'b1;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("disabled pin reset acted");

  property p_sel_a;
    ctrl_q.pin_rst && (sel_q == GBT_SEL_PIN_A) && !ext_irq_pin_a_i |=> cnt_q == '0;
  endproperty
  a_sel_a: assert property (p_sel_a) else $error("pin a low did not clear");

  property p_bad_mode;
    (ctrl_q.mode == GBT_MODE_BAD) && !pin_hit |=> $stable(cnt_q);
  endproperty
  a_bad_mode: assert property (p_bad_mode) else $error("counted in prohibited mode");

  property p_stopped;
    !run && !pin_hit |=> $stable(cnt_q) && $stable(up_q);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counted while stopped");

  property p_turn_top;
    step && !pin_hit && (ctrl_q.mode == GBT_MODE_UPDN) && up_q && (cnt_q == '1)
    |=> !up_q && (cnt_q == $past(cnt_q) - 1'b1);
  endproperty
  a_turn_top: assert property (p_turn_top) else $error("no turn at all-ones");

  property p_match_turn;
    step && !pin_hit && match_hit && (ctrl_q.mode == GBT_MODE_UPDN) && (cnt_q != '1)
    |=> up_q && (pend_q == 2'h1) && (cnt_q == $past(cnt_q) + 1'b1);
  endproperty
  a_match_turn: assert property (p_match_turn) else $error("match turn not armed");

  property p_cmp_split;
    we_i && (addr_i == GBT_OFS_CMP2)
    |=> (cmp_n_o == $past(wdata_i[15:10])) && (cmp_m_o == $past(wdata_i[9:0]));
  endproperty
  a_cmp_split: assert property (p_cmp_split) else $error("compare split wrong");

  property p_pol;
    ##1 group2_serial_tx_pin_o == ($past(tx_data_i) ^ $past(pol_q.tx_pol));
  endproperty
  a_pol: assert property (p_pol) else $error("tx polarity wrong");

  property p_match_clear;
    step && !pin_hit && match_hit && (ctrl_q.mode == GBT_MODE_UP)
    |=> cnt_q == '0;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("match did not clear");

endmodule // gbt_base_timer

/* gbt_pin_model.sv */
/*
  pin-side partner of the group base timer: two external interrupt pins
  and the serial receive pin.
  assumes the bench shares its clock and asks for pin levels by flag.
*/
`timescale 1ns/1ps
module gbt_pin_model (
  input  wire logic clk_i,     // shared bench clock
  input  wire logic low_a_i,   // request: hold pin a low
  input  wire logic low_b_i,   // request: hold pin b low
  input  wire logic rx_i,      // serial level to present
  output logic      pin_a_o,   // external interrupt pin a
  output logic      pin_b_o,   // external interrupt pin b
  output logic      rx_pin_o   // serial receive pin
);
  // interrupt pins idle high through their pull-ups; a low is only ever asked for,
  // and levels move just after the edge like any real driver
  always @(posedge clk_i) begin
    pin_a_o  <= ~low_a_i;
    pin_b_o  <= ~low_b_i;
    rx_pin_o <= rx_i;
  end
endmodule // gbt_pin_model

/* io_group_base_timer_tb.sv */
/*
  self-checking bench for the group base timer, group 0 instance.
  assumes the register map and latencies of the package and hand-over.
*/
`timescale 1ns/1ps
module io_group_base_timer_tb;
  import gbt_pkg::*;
  logic        clk_i = 1'b0;    // 100 MHz
  logic        reset_i = 1'b1;  // async, active high
  logic [4:0]  addr = 5'h00;    // register bus
  logic [31:0] wdata = 32'h0;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic        cen = 1'b0;      // count enable
  logic        pha = 1'b0;      // two-phase inputs
  logic        phb = 1'b0;
  logic        txd = 1'b0;      // internal tx data
  logic        low_a = 1'b0;    // pin requests to the model
  logic        low_b = 1'b0;
  logic        rxv = 1'b0;
  logic        pin_a, pin_b, rx_pin, tx_o, rx_o, cup, rd_seen = 1'b0;
  logic [31:0] rdata;
  logic [15:0] cnt, e;
  logic [5:0]  cn;
  logic [9:0]  cm;
  logic [31:0] seed = 32'h1091;  // xorshift state
  logic [31:0] exp_q[$];         // expected read data, oldest first
  int          errors = 0;
  int          num_checks = 0;
  logic        pa, pb, na, nb;
  always #5 clk_i = ~clk_i;
  gbt_pin_model pin_u (.clk_i(clk_i), .low_a_i(low_a), .low_b_i(low_b), .rx_i(rxv),
    .pin_a_o(pin_a), .pin_b_o(pin_b), .rx_pin_o(rx_pin));
  gbt_base_timer #(.GROUP(0), .CNT_W(16)) dut_u (.clk_i(clk_i), .reset_i(reset_i),
    .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata),
    .count_en_i(cen), .ext_irq_pin_a_i(pin_a), .ext_irq_pin_b_i(pin_b),
    .phase_a_i(pha), .phase_b_i(phb), .tx_data_i(txd), .group2_serial_rx_pin_i(rx_pin),
    .group2_serial_tx_pin_o(tx_o), .rx_data_o(rx_o), .count_o(cnt), .count_up_o(cup),
    .cmp_n_o(cn), .cmp_m_o(cm));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
  endtask
  // the note goes into the queue as the strobe is raised
  task automatic rd(input logic [4:0] a, input logic [31:0] x);
    @(posedge clk_i);
    addr <= a;
    re <= 1'b1;
    exp_q.push_back(x);
    @(posedge clk_i);
    re <= 1'b0;
  endtask
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk_i);
      cen <= 1'b1;
      @(posedge clk_i);
      cen <= 1'b0;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // read data stand only in the cycle after the strobe: compare them there
  always @(posedge clk_i) begin
    if (rd_seen == 1'b1) begin
      if (exp_q.size() > 0) chk(rdata, exp_q.pop_front());
      else chk(rdata, 32'hDEAD_0000);
    end else if (reset_i == 1'b0 && rdata !== 32'h0) begin
      chk(rdata, 32'h0);  // read data must fall back to zero
    end
    rd_seen <= re;
  end
  // hang guard, well past the longest planned run
  initial begin
    #900000;
    errors++;
    give_verdict();
  end
  initial begin
    idle(12);
    reset_i <= 1'b0;
    for (int i = 0; i < 8; i++) rd(5'(i * 4), 32'h0);
    chk(32'(cup), 32'h1);
    $display("reset values done");
    step(2);
    rd(GBT_OFS_COUNT, 32'h0);
    wr(GBT_OFS_START, 32'h1);
    step(3);
    rd(GBT_OFS_COUNT, 32'h3);
    wr(GBT_OFS_START, 32'h0);
    step(1);
    rd(GBT_OFS_COUNT, 32'h3);
    wr(GBT_OFS_START, 32'h2);
    step(1);
    rd(GBT_OFS_COUNT, 32'h4);
    $display("start bits done");
    // pin reset off, then on with pin a, then pin b selected
    low_a <= 1'b1;
    idle(2);
    step(1);
    rd(GBT_OFS_COUNT, 32'h5);
    wr(GBT_OFS_CTRL, 32'h4);
    idle(2);
    rd(GBT_OFS_COUNT, 32'h0);
    low_a <= 1'b0;
    low_b <= 1'b1;
    step(2);
    rd(GBT_OFS_COUNT, 32'h2);
    wr(GBT_OFS_PINSEL, 32'h0040_0000);
    idle(2);
    rd(GBT_OFS_PINSEL, 32'h0040_0000);
    rd(GBT_OFS_COUNT, 32'h0);
    low_b <= 1'b0;
    idle(3);
    step(1);
    rd(GBT_OFS_COUNT, 32'h1);
    $display("pin reset done");
    wr(GBT_OFS_CTRL, 32'h60);
    step(2);
    rd(GBT_OFS_COUNT, 32'h1);
    wr(GBT_OFS_CMP0, 32'h3);
    wr(GBT_OFS_CTRL, 32'h1);
    step(3);
    rd(GBT_OFS_COUNT, 32'h0);
    // up/down with match at 5: up to 7, then down through 0 and back up
    wr(GBT_OFS_CMP0, 32'h5);
    wr(GBT_OFS_CTRL, 32'h21);
    step(7);
    rd(GBT_OFS_COUNT, 32'h7);
    chk(32'(cup), 32'h0);
    step(1);
    rd(GBT_OFS_COUNT, 32'h6);
    step(7);
    rd(GBT_OFS_COUNT, 32'h1);
    chk(32'(cup), 32'h1);
    wr(GBT_OFS_CTRL, 32'h20);
    cen <= 1'b1;
    idle(65534);
    cen <= 1'b0;
    rd(GBT_OFS_COUNT, 32'hFFFF);
    step(1);
    rd(GBT_OFS_COUNT, 32'hFFFE);
    chk(32'(cup), 32'h0);
    chk({16'h0, cnt}, 32'hFFFE);
    $display("up/down done");
    // two-phase: clear by pin b, then random phase walk
    wr(GBT_OFS_CTRL, 32'h44);
    low_b <= 1'b1;
    idle(3);
    low_b <= 1'b0;
    idle(3);
    e = 16'h0;
    pa = 1'b0;
    pb = 1'b0;
    repeat (20) begin
      @(posedge clk_i);
      {na, nb} = xs() >> 7;
      if ({na, nb} != {pa, pb}) e = (na ^ pb) ? e + 16'h1 : e - 16'h1;
      pha <= na;
      phb <= nb;
      pa = na;
      pb = nb;
    end
    idle(2);
    rd(GBT_OFS_COUNT, {16'h0, e});
    $display("two-phase done");
    for (int i = 0; i < 4; i++) begin
      e = (i == 0) ? 16'hFFFF : xs() >> 3;
      wr(GBT_OFS_CMP2, {16'h0, e});
      idle(2);
      #1 chk({16'h0, cn, cm}, {16'h0, e});
    end
    $display("compare split done");
    for (int i = 0; i < 16; i++) begin
      wr(GBT_OFS_G2CR, 32'(i & 3));
      txd <= i[2];
      rxv <= i[3];
      idle(3);
      #1 chk({30'h0, rx_o, tx_o}, {30'h0, i[3] ^ i[1], i[2] ^ i[0]});
    end
    $display("polarity done");
    idle(3);
    give_verdict();
  end
endmodule // io_group_base_timer_tb
